// File: inc/mft_pkg.sv
// Package of the motion filter and trigger control register bank.
// Assumes one clock domain and an APB slave with 32-bit data words.
package mft_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices and byte addresses, four bytes per index.
  localparam int MFT_ADDR_W = 12;
  localparam logic [7:0] MFT_IDX_LOWPASS = 8'h13;
  localparam logic [7:0] MFT_IDX_FILT_TRIG = 8'h15;
  localparam logic [7:0] MFT_IDX_GYRO_MODE = 8'h16;
  localparam logic [7:0] MFT_IDX_STATUS = 8'h20;
  localparam logic [11:0] MFT_ADDR_LOWPASS = {2'h0, MFT_IDX_LOWPASS, 2'h0};
  localparam logic [11:0] MFT_ADDR_FILT_TRIG = {2'h0, MFT_IDX_FILT_TRIG, 2'h0};
  localparam logic [11:0] MFT_ADDR_GYRO_MODE = {2'h0, MFT_IDX_GYRO_MODE, 2'h0};
  localparam logic [11:0] MFT_ADDR_STATUS = {2'h0, MFT_IDX_STATUS, 2'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of filter_trigger_control.
  localparam int MFT_FT_EDGE_BIT = 7;
  localparam int MFT_FT_LEVEL_BIT = 6;
  localparam int MFT_FT_LATCH_BIT = 5;
  localparam int MFT_FT_ACCEL_PD_BIT = 4;
  localparam int MFT_FT_OFS_W_BIT = 3;
  localparam int MFT_FT_BW_HI = 2;
  localparam int MFT_FT_BW_LO = 0;

  // Field positions of gyro_mode_control.
  localparam int MFT_GM_PERF_DIS_BIT = 7;
  localparam int MFT_GM_HP_EN_BIT = 6;
  localparam int MFT_GM_HPM_HI = 5;
  localparam int MFT_GM_HPM_LO = 4;
  localparam int MFT_GM_RSVD_BIT = 3;
  localparam int MFT_GM_STAB_SRC_BIT = 2;
  localparam int MFT_GM_OFS_OUT_BIT = 1;
  localparam int MFT_GM_STAB_ON_BIT = 0;

  // Field position of the lowpass control register.
  localparam int MFT_LP_ONE_EN_BIT = 1;
  localparam logic [7:0] MFT_LP_WMASK = 8'h02;
  localparam logic [7:0] MFT_GM_WMASK = 8'hF7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] MFT_FILT_TRIG_RST = 8'h00;
  localparam logic [7:0] MFT_GYRO_MODE_RST = 8'h00;
  localparam logic [7:0] MFT_LOWPASS_RST = 8'h00;

  // Trigger bit codes, ordered edge, level, latched.
  localparam logic [2:0] MFT_CODE_EDGE = 3'h4;
  localparam logic [2:0] MFT_CODE_LEVEL = 3'h2;
  localparam logic [2:0] MFT_CODE_LATCH = 3'h3;
  localparam logic [2:0] MFT_CODE_GATE = 3'h6;

  // Offset weight as the negative power of two in g per LSB.
  localparam logic [3:0] MFT_OFS_EXP_FINE = 4'hA;
  localparam logic [3:0] MFT_OFS_EXP_COARSE = 4'h6;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    MFT_TRIG_NONE = 3'h0,
    MFT_TRIG_EDGE = 3'h1,
    MFT_TRIG_LEVEL = 3'h3,
    MFT_TRIG_LATCH = 3'h2,
    MFT_TRIG_GATE = 3'h6
  } mft_trig_mode_type;

  typedef struct packed {
    mft_trig_mode_type trig_mode;
    logic accel_hp_on;
    logic [3:0] offset_exp;
    logic gyro_lpf_on;
    logic [2:0] gyro_bw;
    logic gyro_hp_on;
    logic gyro_hpf_on;
    logic [1:0] gyro_hp_mode;
    logic stab_src;
    logic offset_on_out;
    logic stab_on;
  } mft_ctrl_type;

endpackage : mft_pkg

// File: rtl/mft_trigger_decode.sv
// Decoder of the three data-enable trigger bits into a trigger mode.
// Assumes the bits come from registers on the same clock.
`timescale 1ns/100ps
`default_nettype none
module mft_trigger_decode
  import mft_pkg::*;
(
  input wire logic [2:0] trig_bits,
  output mft_pkg::mft_trig_mode_type mode,
  output logic known
);

  always_comb
  begin
    known = 1'b1;
    case (trig_bits)
      MFT_CODE_EDGE: mode = MFT_TRIG_EDGE;
      MFT_CODE_LEVEL: mode = MFT_TRIG_LEVEL;
      MFT_CODE_LATCH: mode = MFT_TRIG_LATCH;
      MFT_CODE_GATE: mode = MFT_TRIG_GATE;
      default:
      begin
        // Code 000 and the undefined codes switch triggering off; only 000 is flagged known.
        mode = MFT_TRIG_NONE;
        known = (trig_bits == 3'h0);
      end
    endcase
  end

endmodule : mft_trigger_decode
`default_nettype wire

// File: rtl/mft_gyro_path.sv
// Derives the effective gyro filter controls from the register fields.
// Assumes all inputs are registers on the same clock.
`timescale 1ns/100ps
`default_nettype none
module mft_gyro_path
  import mft_pkg::*;
(
  input wire logic [7:0] gyro_mode,
  input wire logic lpf_one_en,
  input wire logic [2:0] bw_sel,
  output logic hp_on,
  output logic hpf_on,
  output logic lpf_on,
  output logic [2:0] bw
);

  always_comb
  begin
    hp_on = !gyro_mode[MFT_GM_PERF_DIS_BIT];
    // The high-pass filter needs high-performance mode.
    hpf_on = gyro_mode[MFT_GM_HP_EN_BIT] && hp_on;
    lpf_on = lpf_one_en;
    // The profile is held at zero while the first lowpass is off.
    bw = lpf_one_en ? bw_sel : 3'h0;
  end

endmodule : mft_gyro_path
`default_nettype wire

// File: rtl/mft_regs.sv
// Motion filter and trigger control register bank with an APB slave.
// Assumes an APB master on pclk; the filters and trigger pin logic
// read the ctrl output and live outside this block.
//
// Function
// - Filter trigger register holds eight bit layout.
// - Codes 100 edge and 010 level triggering.
// - Code 011 selects latched level trigger mode.
// - Code 110 gates buffer storage by level.
// - Accel performance disable resets zero, one exits.
// - Offset weight selects two power ten or six.
// - Three bit field picks one of eight profiles.
// - Gyro mode register holds eight bit layout.
// - Gyro performance disable resets zero, one exits.
// - High-pass enable resets zero, needs performance mode.
// - Bandwidth acts only with first lowpass enabled.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module mft_regs
  import mft_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mft_pkg::MFT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output mft_pkg::mft_ctrl_type ctrl
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [7:0] filt_q;
  logic [7:0] filt_d;
  logic [7:0] gyro_q;
  logic [7:0] gyro_d;
  logic [7:0] lowp_q;
  logic [7:0] lowp_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  mft_ctrl_type ctrl_q;
  mft_ctrl_type ctrl_d;

  logic setup;
  logic wr_take;
  logic hit;
  logic [7:0] status;
  mft_trig_mode_type trig_mode;
  logic trig_known;
  logic g_hp_on;
  logic g_hpf_on;
  logic g_lpf_on;
  logic [2:0] g_bw;

  ////////////////////////////////////////////////////////////////////////////
  // Decoders.
  mft_trigger_decode u_trig (
    .trig_bits(filt_q[MFT_FT_EDGE_BIT:MFT_FT_LATCH_BIT]),
    .mode(trig_mode),
    .known(trig_known)
  );

  mft_gyro_path u_gyro (
    .gyro_mode(gyro_q),
    .lpf_one_en(lowp_q[MFT_LP_ONE_EN_BIT]),
    .bw_sel(filt_q[MFT_FT_BW_HI:MFT_FT_BW_LO]),
    .hp_on(g_hp_on),
    .hpf_on(g_hpf_on),
    .lpf_on(g_lpf_on),
    .bw(g_bw)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave. The answer is prepared in the setup cycle, so every access
  // completes in the first access cycle with registered outputs.
  always_comb
  begin
    setup = psel && !penable;
    wr_take = psel && penable && pready_q && pwrite && !pslverr_q;
    hit = (paddr == MFT_ADDR_FILT_TRIG) || (paddr == MFT_ADDR_GYRO_MODE) ||
      (paddr == MFT_ADDR_LOWPASS) || (paddr == MFT_ADDR_STATUS);
    status = {trig_known, ctrl_q.trig_mode, ctrl_q.gyro_hpf_on,
      ctrl_q.gyro_lpf_on, ctrl_q.accel_hp_on, ctrl_q.gyro_hp_on};
    pready_d = setup;
    pslverr_d = setup && (!hit || (pwrite && (paddr == MFT_ADDR_STATUS)));
    prdata_d = prdata_q;
    if (setup)
    begin
      prdata_d = 32'h0000_0000;
      if (!pwrite)
      begin
        case (paddr)
          MFT_ADDR_FILT_TRIG: prdata_d[7:0] = filt_q;
          MFT_ADDR_GYRO_MODE: prdata_d[7:0] = gyro_q;
          MFT_ADDR_LOWPASS: prdata_d[7:0] = lowp_q;
          MFT_ADDR_STATUS: prdata_d[7:0] = status;
          default: prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes take effect at the completing edge, lane zero only.
  always_comb
  begin
    filt_d = filt_q;
    gyro_d = gyro_q;
    lowp_d = lowp_q;
    if (wr_take && pstrb[0])
    begin
      case (paddr)
        MFT_ADDR_FILT_TRIG: filt_d = pwdata[7:0];
        // The reserved bit is never stored, so a careless write cannot
        // upset the gyro path.
        MFT_ADDR_GYRO_MODE: gyro_d = pwdata[7:0] & MFT_GM_WMASK;
        MFT_ADDR_LOWPASS: lowp_d = pwdata[7:0] & MFT_LP_WMASK;
        default: filt_d = filt_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded controls for the filter and trigger logic.
  always_comb
  begin
    ctrl_d.trig_mode = trig_mode;
    ctrl_d.accel_hp_on = !filt_q[MFT_FT_ACCEL_PD_BIT];
    ctrl_d.offset_exp = filt_q[MFT_FT_OFS_W_BIT] ? MFT_OFS_EXP_COARSE : MFT_OFS_EXP_FINE;
    ctrl_d.gyro_lpf_on = g_lpf_on;
    ctrl_d.gyro_bw = g_bw;
    ctrl_d.gyro_hp_on = g_hp_on;
    ctrl_d.gyro_hpf_on = g_hpf_on;
    ctrl_d.gyro_hp_mode = gyro_q[MFT_GM_HPM_HI:MFT_GM_HPM_LO];
    ctrl_d.stab_src = gyro_q[MFT_GM_STAB_SRC_BIT];
    ctrl_d.offset_on_out = gyro_q[MFT_GM_OFS_OUT_BIT];
    ctrl_d.stab_on = gyro_q[MFT_GM_STAB_ON_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filt_q <= MFT_FILT_TRIG_RST;
      gyro_q <= MFT_GYRO_MODE_RST;
      lowp_q <= MFT_LOWPASS_RST;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      ctrl_q <= '0;
    end
    else
    begin
      filt_q <= filt_d;
      gyro_q <= gyro_d;
      lowp_q <= lowp_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ctrl = ctrl_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_edge_code: assert property (
    filt_q[7:5] == 3'h4 |=> ctrl_q.trig_mode == MFT_TRIG_EDGE)
    else $error("Edge code did not select edge trigger.");

  a_level_code: assert property (
    filt_q[7:5] == 3'h2 |=> ctrl_q.trig_mode == MFT_TRIG_LEVEL)
    else $error("Level code did not select level trigger.");

  a_latch_code: assert property (
    filt_q[7:5] == 3'h3 |=> ctrl_q.trig_mode == MFT_TRIG_LATCH)
    else $error("Latched code did not select latched mode.");

  a_gate_code: assert property (
    filt_q[7:5] == 3'h6 |=> ctrl_q.trig_mode == MFT_TRIG_GATE)
    else $error("Gate code did not select buffer gate mode.");

  // The decoded controls lag the registers by one cycle and still hold their
  // reset value at the edge after release, hence the guard on the past reset.
  a_accel_perf: assert property (
    $past(presetn) |-> ctrl_q.accel_hp_on == !$past(filt_q[4]))
    else $error("Accel performance mode does not follow its bit.");

  a_offset_weight: assert property (
    $past(presetn) |-> ctrl_q.offset_exp == ($past(filt_q[3]) ? 4'h6 : 4'hA))
    else $error("Offset weight exponent is wrong.");

  a_bw_follow: assert property (
    lowp_q[1] |=> ctrl_q.gyro_lpf_on && ctrl_q.gyro_bw == $past(filt_q[2:0]))
    else $error("Bandwidth profile does not follow its field.");

  a_bw_idle: assert property (
    !lowp_q[1] |=> !ctrl_q.gyro_lpf_on && ctrl_q.gyro_bw == 3'h0)
    else $error("Bandwidth acts without the first lowpass.");

  a_hp_needs_perf: assert property (
    gyro_q[7] |=> !ctrl_q.gyro_hpf_on && !ctrl_q.gyro_hp_on)
    else $error("High-pass active outside performance mode.");

  a_write_filt: assert property (
    wr_take && pstrb[0] && paddr == 12'h054 |=> filt_q == $past(pwdata[7:0]))
    else $error("Filter trigger write did not land.");

  a_write_gyro: assert property (
    wr_take && pstrb[0] && paddr == 12'h058
      |=> gyro_q == ($past(pwdata[7:0]) & 8'hF7) && gyro_q[3] == 1'b0)
    else $error("Gyro mode write did not land.");

  a_ready_pulse: assert property (
    setup |=> pready_q ##1 !pready_q)
    else $error("Ready is not a single cycle answer.");

  ////////////////////////////////////////////////////////////////////////////
  // Decoded gyro and trigger controls.
  a_other_code: assert property (
    !(filt_q[7:5] inside {3'h4, 3'h2, 3'h3, 3'h6}) |=> ctrl_q.trig_mode == MFT_TRIG_NONE)
    else $error("Undefined code did not switch triggering off.");

  a_gyro_perf: assert property (
    $past(presetn) |-> ctrl_q.gyro_hp_on == !$past(gyro_q[7]))
    else $error("Gyro performance mode does not follow its bit.");

  a_hpf_follow: assert property (
    gyro_q[6] && !gyro_q[7] |=> ctrl_q.gyro_hpf_on)
    else $error("High-pass not active with its enable in performance mode.");

  a_hp_mode: assert property (
    $past(presetn) |-> ctrl_q.gyro_hp_mode == $past(gyro_q[5:4]))
    else $error("High-pass mode does not follow its field.");

  a_stab_fields: assert property (
    $past(presetn)
      |-> {ctrl_q.stab_src, ctrl_q.offset_on_out, ctrl_q.stab_on} == $past(gyro_q[2:0]))
    else $error("Stabilisation or offset output bits do not follow.");

  ////////////////////////////////////////////////////////////////////////////
  // Bus answers.
  a_read_filt: assert property (
    setup && !pwrite && paddr == 12'h054 |=> prdata_q == {24'h0, $past(filt_q)})
    else $error("Filter trigger read returned the wrong word.");

  a_read_gyro: assert property (
    setup && !pwrite && paddr == 12'h058 |=> prdata_q == {24'h0, $past(gyro_q)})
    else $error("Gyro mode read returned the wrong word.");

  a_read_lowp: assert property (
    setup && !pwrite && paddr == 12'h04C |=> prdata_q == {24'h0, $past(lowp_q)})
    else $error("Lowpass control read returned the wrong word.");

  a_lowp_write: assert property (
    wr_take && pstrb[0] && paddr == 12'h04C |=> lowp_q == ($past(pwdata[7:0]) & 8'h02))
    else $error("Lowpass control write did not land.");

  a_ok_answer: assert property (
    setup && hit && !(pwrite && paddr == 12'h080) |=> pready_q && !pslverr_q)
    else $error("Mapped access was not answered without error.");

  a_err_answer: assert property (
    setup && (!hit || (pwrite && paddr == 12'h080)) |=> pready_q && pslverr_q)
    else $error("Refused access was not answered with an error.");

  // A refused write, or one without lane zero, must leave every register alone.
  a_err_no_effect: assert property (
    setup && pwrite && (!hit || paddr == 12'h080 || !pstrb[0])
      |=> ##1 $stable(filt_q) && $stable(gyro_q) && $stable(lowp_q))
    else $error("Refused or masked write changed a register.");

  a_rdata_hold: assert property (
    !setup |=> $stable(prdata_q))
    else $error("Read data changed outside a setup cycle.");

  // Status carries the decoded mode, so every bit but the known flag trails the register by one cycle.
  a_status_read: assert property (
    setup && !pwrite && paddr == 12'h080
      |=> prdata_q[31:8] == 24'h0 && prdata_q[6:4] == $past(ctrl_q.trig_mode))
    else $error("Status read does not show the decoded mode.");

  a_status_known: assert property (
    setup && !pwrite && paddr == 12'h080 && filt_q[7:5] == 3'h2 |=> prdata_q[7])
    else $error("Status does not flag a listed trigger code.");

endmodule : mft_regs
`default_nettype wire

// File: tb/mft_regs_tb.sv
// Self-checking bench of the filter and trigger control register bank.
// Assumes an APB slave on pclk that may stretch the access phase.
`timescale 1ns/100ps
`default_nettype none
module mft_regs_tb;
  import mft_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  mft_ctrl_type ctrl;
  logic [31:0] rdv;
  logic erv;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  always #10 pclk = ~pclk;

  mft_regs dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ctrl(ctrl)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // The run is under two hundred cycles; the ceiling leaves ample margin.
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fail_count++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One APB transfer; the master waits for pready, however long it takes.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Read right after the edge, the outputs still show the values sampled there.
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hF);
    repeat (2) @(posedge pclk);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 8'h00, 4'hF);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(MFT_ADDR_FILT_TRIG);
    check("ft reset", rdv, 32'h00000000);
    rd(MFT_ADDR_GYRO_MODE);
    check("gm reset", rdv, 32'h00000000);
    check("accel hp", {31'h0, ctrl.accel_hp_on}, 32'h1);
    check("gyro hp", {31'h0, ctrl.gyro_hp_on}, 32'h1);
    check("hpf", {31'h0, ctrl.gyro_hpf_on}, 32'h0);
    check("ofs exp", {28'h0, ctrl.offset_exp}, {28'h0, MFT_OFS_EXP_FINE});
  endtask : t_reset

  task automatic t_trig();
    logic [2:0] codes [5] = '{3'h4, 3'h2, 3'h3, 3'h6, 3'h0};
    mft_trig_mode_type modes [5] = '{MFT_TRIG_EDGE, MFT_TRIG_LEVEL, MFT_TRIG_LATCH,
                                     MFT_TRIG_GATE, MFT_TRIG_NONE};
    for (int i = 0; i < 5; i++)
    begin
      wr(MFT_ADDR_FILT_TRIG, {codes[i], 5'h00});
      check("trig", {29'h0, ctrl.trig_mode}, {29'h0, modes[i]});
      rd(MFT_ADDR_FILT_TRIG);
      check("ft back", rdv, {24'h0, codes[i], 5'h00});
    end
  endtask : t_trig

  task automatic t_accel();
    wr(MFT_ADDR_FILT_TRIG, 8'h18);
    check("accel hp", {31'h0, ctrl.accel_hp_on}, 32'h0);
    check("ofs exp", {28'h0, ctrl.offset_exp}, {28'h0, MFT_OFS_EXP_COARSE});
  endtask : t_accel

  task automatic t_bw();
    wr(MFT_ADDR_LOWPASS, 8'h02);
    rd(MFT_ADDR_LOWPASS);
    check("lp back", rdv, 32'h00000002);
    check("lpf on", {31'h0, ctrl.gyro_lpf_on}, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      wr(MFT_ADDR_FILT_TRIG, 8'(i));
      check("bw", {29'h0, ctrl.gyro_bw}, 32'(i));
    end
    wr(MFT_ADDR_LOWPASS, 8'h00);
    check("bw off", {29'h0, ctrl.gyro_bw}, 32'h0);
    check("lpf off", {31'h0, ctrl.gyro_lpf_on}, 32'h0);
    rd(MFT_ADDR_FILT_TRIG);
    check("bw back", rdv, 32'h00000007);
  endtask : t_bw

  task automatic t_gyro();
    // Reserved bit 3 stays clear in every write, as software must keep it.
    wr(MFT_ADDR_GYRO_MODE, 8'hF7);
    rd(MFT_ADDR_GYRO_MODE);
    check("gm back", rdv, 32'h000000F7);
    check("gyro hp", {31'h0, ctrl.gyro_hp_on}, 32'h0);
    check("hpf gated", {31'h0, ctrl.gyro_hpf_on}, 32'h0);
    check("stab", {29'h0, ctrl.stab_src, ctrl.offset_on_out, ctrl.stab_on}, 32'h7);
    wr(MFT_ADDR_GYRO_MODE, 8'h60);
    check("hpf on", {31'h0, ctrl.gyro_hpf_on}, 32'h1);
    check("hp mode", {30'h0, ctrl.gyro_hp_mode}, 32'h2);
    check("gyro hp", {31'h0, ctrl.gyro_hp_on}, 32'h1);
  endtask : t_gyro

  task automatic t_errors();
    wr(MFT_ADDR_FILT_TRIG, 8'h44);
    apb(1'b1, 12'h0FC, 8'hFF, 4'hF);
    check("unmapped", {31'h0, erv}, 32'h1);
    apb(1'b1, MFT_ADDR_STATUS, 8'hFF, 4'hF);
    check("status wr", {31'h0, erv}, 32'h1);
    apb(1'b1, MFT_ADDR_FILT_TRIG, 8'hFF, 4'hE);
    check("strobe err", {31'h0, erv}, 32'h0);
    rd(MFT_ADDR_FILT_TRIG);
    check("ft kept", rdv, 32'h00000044);
    rd(12'h0FC);
    check("unmapped rd", {31'h0, erv}, 32'h1);
    // Level code, gyro in performance mode with high-pass on, lowpass off.
    rd(MFT_ADDR_STATUS);
    check("status", rdv, 32'h000000BB);
  endtask : t_errors

  task automatic t_midreset();
    // A reset in mid-run must clear every field written before it.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(MFT_ADDR_GYRO_MODE);
    check("gm cleared", rdv, 32'h00000000);
    rd(MFT_ADDR_FILT_TRIG);
    check("ft cleared", rdv, 32'h00000000);
    check("hpf cleared", {31'h0, ctrl.gyro_hpf_on}, 32'h0);
    check("accel hp", {31'h0, ctrl.accel_hp_on}, 32'h1);
  endtask : t_midreset

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_trig();
    t_accel();
    t_bw();
    t_gyro();
    t_errors();
    t_midreset();
    finish_test();
  end
endmodule : mft_regs_tb
`default_nettype wire
